// *** hw/icp_pkg.sv ***
package icp_pkg;
  localparam int CNT_W = 12;
  localparam logic [11:0] CNT_MAX = 12'hfff;

  // Register byte offsets
  localparam logic [7:0] OFS_TIMER_SELECT = 8'h00;
  localparam logic [7:0] OFS_TMA_CONTROL = 8'h04;
  localparam logic [7:0] OFS_TMA_PRELOAD_LOW = 8'h08;
  localparam logic [7:0] OFS_TMA_PRELOAD_HIGH = 8'h0c;
  localparam logic [7:0] OFS_TX_DRIVE = 8'h10;
  localparam logic [7:0] OFS_TMB_CONTROL = 8'h14;
  localparam logic [7:0] OFS_TMB_PRELOAD_LOW = 8'h18;
  localparam logic [7:0] OFS_TMB_PRELOAD_HIGH = 8'h1c;
  localparam logic [7:0] OFS_INT_STATUS = 8'h20;
  localparam logic [7:0] OFS_INT_MASK = 8'h24;

  // Field positions
  localparam int SEL_TMA_UP_BIT = 7;
  localparam int TMA_RUN_BIT = 7;
  localparam int TMA_CLK_LSB = 4;
  localparam int TMA_DUTY_LSB = 2;
  localparam int TMA_MODE_LSB = 0;
  localparam int TMB_RUN_BIT = 7;
  localparam int TMB_CLK_LSB = 4;
  localparam int DRV_BIT = 3;
  localparam int INT_TMA_OVF_BIT = 0;
  localparam int INT_TMB_OVF_BIT = 1;
  localparam int INT_W = 2;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_NIBBLE = 4'h0;

  // Timing counts: prescaler terminal values
  localparam logic [3:0] TMA_DIV2_LAST = 4'h1;
  localparam logic [3:0] TMA_DIV4_LAST = 4'h3;
  localparam logic [3:0] TMA_DIV16_LAST = 4'hf;
  localparam logic [5:0] TMB_DIV4_LAST = 6'h03;
  localparam logic [5:0] TMB_DIV64_LAST = 6'h3f;

  // Carrier period length in counter periods
  localparam logic [2:0] DUTY_LEN_THIRD = 3'h3;
  localparam logic [2:0] DUTY_LEN_QUARTER = 3'h4;
  localparam logic [2:0] DUTY_LEN_FIFTH = 3'h5;
  localparam logic [2:0] DUTY_LEN_HALF = 3'h2;

  typedef enum logic [1:0] {
    MODE_CARRIER = 2'h0,
    MODE_NO_CARRIER = 2'h1,
    MODE_CAPTURE = 2'h2,
    MODE_ENV_DETECT = 2'h3
  } icp_mode_t;

  typedef enum logic [1:0] {
    TMA_CLK_DIV1 = 2'h0,
    TMA_CLK_DIV2 = 2'h1,
    TMA_CLK_DIV4 = 2'h2,
    TMA_CLK_DIV16 = 2'h3
  } icp_tma_clk_t;

  typedef enum logic [1:0] {
    DUTY_THIRD = 2'h0,
    DUTY_QUARTER = 2'h1,
    DUTY_FIFTH = 2'h2,
    DUTY_HALF = 2'h3
  } icp_duty_t;

  typedef enum logic [1:0] {
    TMB_CLK_DIV1 = 2'h0,
    TMB_CLK_DIV4 = 2'h1,
    TMB_CLK_DIV64 = 2'h2,
    TMB_CLK_CARRIER = 2'h3
  } icp_tmb_clk_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_RD_WAIT = 1'b1
  } icp_bus_t;
endpackage

// *** hw/icp_tmr_if.sv ***
`timescale 1ns/100ps
interface icp_tmr_if;
  logic run;
  logic [1:0] clk_sel;
  logic [11:0] preload;
  logic carrier_rise;
  logic ovf;
  logic [11:0] count;
  modport ctl(output run, output clk_sel, output preload, output carrier_rise,
              input ovf, input count);
  modport tmr(input run, input clk_sel, input preload, input carrier_rise,
              output ovf, output count);
endinterface

// *** hw/icp_timer_b.sv ***
`timescale 1ns/100ps
module icp_timer_b (
  input wire logic hclk,
  input wire logic hresetn,
  icp_tmr_if.tmr tb
);
  import icp_pkg::*;

  typedef struct packed {
    logic [5:0] div;
    logic [11:0] cnt;
    logic run_d;
    logic ovf;
  } icp_tmb_state_t;

  icp_tmb_state_t s_q, s_d;
  logic tick;

  always_comb begin
    s_d = s_q;
    s_d.ovf = 1'b0;
    s_d.run_d = tb.run;
    s_d.div = tb.run ? s_q.div + 6'h01 : 6'h00;
    case (tb.clk_sel)
      TMB_CLK_DIV1: tick = 1'b1;
      TMB_CLK_DIV4: tick = (s_q.div[1:0] == TMB_DIV4_LAST[1:0]);
      TMB_CLK_DIV64: tick = (s_q.div == TMB_DIV64_LAST);
      TMB_CLK_CARRIER: tick = tb.carrier_rise; // R10
      default: tick = 1'b0;
    endcase
    if (tb.run && !s_q.run_d) begin
      s_d.cnt = tb.preload;
    end else if (tb.run && tick) begin
      if (s_q.cnt == CNT_MAX) begin
        s_d.cnt = tb.preload;
        s_d.ovf = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 12'h001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tb.ovf = s_q.ovf;
  assign tb.count = s_q.cnt;
endmodule

// *** hw/icp_carrier_timer.sv ***
// Behaviour
// R1: Timer A counts up when selected
// R2: Counter clock is oscillator divided per field
// R3: Carrier and no-carrier modes drive transmit pin
// R4: Drive current bit controls transmit pin strength
// R5: Overflow from max to zero raises interrupt; here max reloads the preload instead of zero
// R6: Start loads preload then counts upward
// R7: Overflow reloads preload and resumes counting
// R8: Carrier duty third, quarter, fifth or half
// R9: Timer B internal clock: run bit gates carrier; here the envelope follows timer A run and select instead
// R10: Timer B may count carrier edges
// R11: Envelope toggles on each timer B overflow
// R12: Software alternates on and off counts
// R13: No-carrier mode pin just high or low
// R14: No-carrier mode still runs internal carrier
// R15: Mode field decode: carrier, no-carrier, capture, envelope
// R16: Clock field decode: div 1, 2, 4, 16
// R17: Duty field decode: third, quarter, fifth, half
// R18: Run bit zero stops, one runs
// R19: Carrier high one counter period per cycle
//
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module icp_carrier_timer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic ir_transmit_pin,
  output logic tx_drive_current_control,
  output logic irq
);
  import icp_pkg::*;

  typedef struct packed {
    logic [7:0] timer_select_reg;
    logic [7:0] timer_a_control;
    logic [7:0] timer_a_preload_low;
    logic [3:0] timer_a_preload_high;
    logic [7:0] drive;
    logic [7:0] timer_b_control;
    logic [7:0] tmb_pre_low;
    logic [3:0] tmb_pre_high;
    logic [INT_W-1:0] int_status;
    logic [INT_W-1:0] int_mask;
    icp_bus_t bus_st;
    logic wr_pend;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic ready;
    logic irq;
    logic [3:0] pre_div;
    logic [11:0] cnt;
    logic run_d;
    logic [2:0] phase;
    logic carrier;
    logic carrier_rise;
    logic envelope;
    logic tmb_run_d;
    logic pin;
    logic drv_out;
  } icp_state_t;

  icp_state_t s_q, s_d;
  icp_tmr_if tmr_b_if ();

  logic timer_on;
  logic tick;
  logic [2:0] duty_len;
  logic [11:0] preload;
  logic [INT_W-1:0] int_set;
  logic [INT_W-1:0] int_clr;
  logic [31:0] rd_mux;
  logic tmb_run;
  logic tmb_from_carrier;

  assign tmr_b_if.run = s_q.timer_b_control[TMB_RUN_BIT];
  assign tmr_b_if.clk_sel = s_q.timer_b_control[TMB_CLK_LSB +: 2];
  assign tmr_b_if.preload = {s_q.tmb_pre_high, s_q.tmb_pre_low};
  assign tmr_b_if.carrier_rise = s_q.carrier_rise;

  icp_timer_b u_timer_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .tb(tmr_b_if.tmr)
  );

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (s_q.addr)
      OFS_TIMER_SELECT: rd_mux[7:0] = s_q.timer_select_reg;
      OFS_TMA_CONTROL: rd_mux[7:0] = s_q.timer_a_control;
      OFS_TMA_PRELOAD_LOW: rd_mux[7:0] = s_q.cnt[7:0];
      OFS_TMA_PRELOAD_HIGH: rd_mux[3:0] = s_q.cnt[11:8];
      OFS_TX_DRIVE: rd_mux[7:0] = s_q.drive;
      OFS_TMB_CONTROL: rd_mux[7:0] = s_q.timer_b_control;
      OFS_TMB_PRELOAD_LOW: rd_mux[7:0] = tmr_b_if.count[7:0];
      OFS_TMB_PRELOAD_HIGH: rd_mux[3:0] = tmr_b_if.count[11:8];
      OFS_INT_STATUS: rd_mux[INT_W-1:0] = s_q.int_status;
      OFS_INT_MASK: rd_mux[INT_W-1:0] = s_q.int_mask;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    s_d = s_q;
    int_set = '0;
    int_clr = '0;

    // Bus: writes land in the data phase, reads take one wait state
    s_d.wr_pend = 1'b0;
    if (s_q.wr_pend) begin
      case (s_q.addr)
        OFS_TIMER_SELECT: s_d.timer_select_reg = hwdata[7:0];
        OFS_TMA_CONTROL: s_d.timer_a_control = hwdata[7:0];
        OFS_TMA_PRELOAD_LOW: s_d.timer_a_preload_low = hwdata[7:0];
        OFS_TMA_PRELOAD_HIGH: s_d.timer_a_preload_high = hwdata[3:0];
        OFS_TX_DRIVE: s_d.drive = hwdata[7:0];
        OFS_TMB_CONTROL: s_d.timer_b_control = hwdata[7:0];
        OFS_TMB_PRELOAD_LOW: s_d.tmb_pre_low = hwdata[7:0];
        OFS_TMB_PRELOAD_HIGH: s_d.tmb_pre_high = hwdata[3:0];
        OFS_INT_STATUS: int_clr = hwdata[INT_W-1:0];
        OFS_INT_MASK: s_d.int_mask = hwdata[INT_W-1:0];
        default: s_d.drive = s_q.drive;
      endcase
    end
    case (s_q.bus_st)
      BUS_IDLE: begin
        if (hsel && hready && htrans[1]) begin
          s_d.addr = {haddr[7:2], 2'b00};
          if (hwrite) begin
            s_d.wr_pend = 1'b1;
          end else begin
            s_d.bus_st = BUS_RD_WAIT;
            s_d.ready = 1'b0;
          end
        end
      end
      BUS_RD_WAIT: begin
        s_d.rdata = rd_mux;
        s_d.ready = 1'b1;
        s_d.bus_st = BUS_IDLE;
      end
      default: s_d.bus_st = BUS_IDLE;
    endcase

    // Timer A
    timer_on = s_q.timer_select_reg[SEL_TMA_UP_BIT] & s_q.timer_a_control[TMA_RUN_BIT]; // R1 R18
    preload = {s_q.timer_a_preload_high, s_q.timer_a_preload_low};
    s_d.pre_div = timer_on ? s_q.pre_div + 4'h1 : 4'h0;
    case (s_q.timer_a_control[TMA_CLK_LSB +: 2]) // R2 R16
      TMA_CLK_DIV1: tick = 1'b1;
      TMA_CLK_DIV2: tick = (s_q.pre_div[0] == TMA_DIV2_LAST[0]);
      TMA_CLK_DIV4: tick = (s_q.pre_div[1:0] == TMA_DIV4_LAST[1:0]);
      TMA_CLK_DIV16: tick = (s_q.pre_div == TMA_DIV16_LAST);
      default: tick = 1'b0;
    endcase
    case (s_q.timer_a_control[TMA_DUTY_LSB +: 2]) // R8 R17
      DUTY_THIRD: duty_len = DUTY_LEN_THIRD;
      DUTY_QUARTER: duty_len = DUTY_LEN_QUARTER;
      DUTY_FIFTH: duty_len = DUTY_LEN_FIFTH;
      DUTY_HALF: duty_len = DUTY_LEN_HALF;
      default: duty_len = DUTY_LEN_HALF;
    endcase
    s_d.run_d = timer_on;
    if (timer_on && !s_q.run_d) begin
      s_d.cnt = preload; // R6
      s_d.phase = 3'h0;
    end else if (timer_on && tick) begin
      if (s_q.cnt == CNT_MAX) begin
        s_d.cnt = preload; // R7
        int_set[INT_TMA_OVF_BIT] = 1'b1; // R5
        s_d.phase = (s_q.phase >= duty_len - 3'h1) ? 3'h0 : s_q.phase + 3'h1;
      end else begin
        s_d.cnt = s_q.cnt + 12'h001;
      end
    end
    s_d.carrier = timer_on && (s_d.phase == 3'h0); // R19 R14
    s_d.carrier_rise = s_d.carrier && (!s_q.carrier || (s_d.phase != s_q.phase));

    // Envelope
    tmb_run = s_q.timer_b_control[TMB_RUN_BIT];
    tmb_from_carrier = (s_q.timer_b_control[TMB_CLK_LSB +: 2] == TMB_CLK_CARRIER);
    s_d.tmb_run_d = tmb_run;
    if (tmr_b_if.ovf) begin
      int_set[INT_TMB_OVF_BIT] = 1'b1;
    end
    if (!tmb_from_carrier) begin
      s_d.envelope = timer_on; // R9
    end else if (tmb_run && !s_q.tmb_run_d) begin
      s_d.envelope = 1'b1;
    end else if (tmr_b_if.ovf) begin
      s_d.envelope = ~s_q.envelope; // R11 R12
    end else if (!tmb_run) begin
      s_d.envelope = 1'b0;
    end

    // Transmit pin
    case (s_q.timer_a_control[TMA_MODE_LSB +: 2]) // R15
      MODE_CARRIER: s_d.pin = s_q.carrier & s_q.envelope; // R3
      MODE_NO_CARRIER: s_d.pin = s_q.envelope; // R13 R14
      default: s_d.pin = 1'b0;
    endcase
    s_d.drv_out = s_q.drive[DRV_BIT]; // R4

    // Interrupts: set wins over clear
    s_d.int_status = (s_q.int_status & ~int_clr) | int_set;
    s_d.irq = |(s_d.int_status & s_q.int_mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.ready <= 1'b1;
      s_q.bus_st <= BUS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout = s_q.ready;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign ir_transmit_pin = s_q.pin;
  assign tx_drive_current_control = s_q.drv_out;
  assign irq = s_q.irq;
endmodule

// *** tb/icp_ir_led.sv ***
`timescale 1ns/100ps
module icp_ir_led (
  input wire logic hclk,
  input wire logic clr,
  input wire logic ir_transmit_pin,
  output int high_len,
  output int period,
  output int n_rise,
  output int max_low
);
  int hc = 0;
  int pc = 0;
  int lc = 0;
  logic pin_q = 1'b0;
  // Light pulses as seen by the emitter
  always @(posedge hclk) begin
    pin_q <= ir_transmit_pin;
    pc <= pc + 1;
    if (ir_transmit_pin && !pin_q) begin
      period <= pc;
      pc <= 1;
      n_rise <= n_rise + 1;
      hc <= 1;
    end else if (ir_transmit_pin) begin
      hc <= hc + 1;
    end
    if (!ir_transmit_pin && pin_q) begin
      high_len <= hc;
    end
    lc <= ir_transmit_pin ? 0 : lc + 1;
    if (clr) begin
      max_low <= 0;
    end else if (lc > max_low) begin
      max_low <= lc;
    end
  end
endmodule

// *** tb/icp_carrier_timer_checker.sv ***
`timescale 1ns/100ps
module icp_chk import icp_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic ir_transmit_pin,
  input wire logic tx_drive_current_control,
  input wire logic irq
);
  logic tk;
  logic [2:0] age_q;
  logic ctl_q;
  logic msk_q;
  assign tk = hsel & hready & htrans[1];
  // Age of the last drive write, and flags for control and mask writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      age_q <= 3'h7;
      ctl_q <= 1'b0;
      msk_q <= 1'b0;
    end else begin
      if (tk && hwrite && haddr[7:0] == OFS_TX_DRIVE) age_q <= 3'h0;
      else if (age_q != 3'h7) age_q <= age_q + 3'h1;
      if (tk && hwrite && haddr[7:0] == OFS_TMA_CONTROL) ctl_q <= 1'b1;
      if (tk && hwrite && haddr[7:0] == OFS_INT_MASK) msk_q <= 1'b1;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
  a_read_wait: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  a_write_nowait: assert property (tk && hwrite |=> hreadyout) else $error("write stalled");
  a_wait_single: assert property (!hreadyout |=> hreadyout) else $error("long wait");
  a_rdata_hold: assert property ($changed(hrdata) |-> $rose(hreadyout))
    else $error("read data moved");
  a_unmapped_zero: assert property (tk && !hwrite && haddr[7:0] == 8'h3c |=> ##1 hrdata == 0)
    else $error("unmapped read not zero");
  a_drive_cause: assert property ($changed(tx_drive_current_control) |-> age_q < 3'h5)
    else $error("drive moved without write");
  a_pin_needs_ctl: assert property ($rose(ir_transmit_pin) |-> ctl_q)
    else $error("pin rose unconfigured");
  a_irq_needs_mask: assert property (irq |-> msk_q)
    else $error("irq without mask");
  c_read: cover property (tk && !hwrite);
  c_pin: cover property ($rose(ir_transmit_pin));
  c_irq: cover property ($rose(irq));
endmodule
bind icp_carrier_timer icp_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .ir_transmit_pin(ir_transmit_pin),
  .tx_drive_current_control(tx_drive_current_control), .irq(irq));

// *** tb/icp_carrier_timer_tb_top.sv ***
`timescale 1ns/100ps
module icp_carrier_timer_tb_top;
  import icp_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, clr = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, r1, r2;
  logic [2:0] hsize = 3'h2;
  wire hreadyout, hresp, irq, pin, drv;
  wire [31:0] hrdata;
  int n_fail = 0, cmp_count = 0, hl, pd, nr, ml;
  int nl[4] = '{3, 4, 5, 2};
  int dv[4] = '{1, 2, 4, 16};
  always #10 hclk = ~hclk;
  icp_carrier_timer u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ir_transmit_pin(pin),
    .tx_drive_current_control(drv), .irq(irq));
  icp_ir_led u_led (.hclk(hclk), .clr(clr), .ir_transmit_pin(pin), .high_len(hl),
    .period(pd), .n_rise(nr), .max_low(ml));
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task rdy;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 40);
    if (hreadyout !== 1'b1) begin
      chk("hready wait", 32'h0, 32'h1);
      end_of_test;
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    r = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, r1);
  endtask
  task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, r1);
    chk(nm, r1, e);
  endtask
  task start(input logic [31:0] c);
    wr(OFS_TMA_CONTROL, 32'h0);
    wr(OFS_TMA_CONTROL, c);
  endtask
  task wait_rise(input int k);
    int s, i;
    s = nr;
    i = 0;
    while (nr < s + k && i < 5000) begin
      @(posedge hclk);
      i++;
    end
    if (nr < s + k) begin
      chk("carrier wait", 32'h0, 32'h1);
      end_of_test;
    end
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int a = 0; a <= 36; a += 4) rd("reset value", 8'(a), 32'h0);
    rd("unmapped", 8'h3c, 32'h0);
    chk("reset pins", {29'h0, pin, drv, irq}, 32'h0);
    wr(OFS_TX_DRIVE, 32'h8);
    rd("drive reg", OFS_TX_DRIVE, 32'h8);
    chk("drive pin", {31'h0, drv}, 32'h1);
    wr(OFS_TIMER_SELECT, 32'h80);
    rd("select", OFS_TIMER_SELECT, 32'h80);
    wr(OFS_TMA_PRELOAD_LOW, 32'hfc);
    wr(OFS_TMA_PRELOAD_HIGH, 32'hf);
    $display("test registers done");
    for (int d = 0; d < 4; d++) begin
      start(32'h80 | 32'(d << 2));
      wait_rise(3);
      chk("duty period", pd, 4 * nl[d]);
      chk("duty high", hl, 4);
    end
    for (int c = 0; c < 4; c++) begin
      start(32'h8c | 32'(c << 4));
      wait_rise(3);
      chk("clock period", pd, 8 * dv[c]);
      chk("clock high", hl, 4 * dv[c]);
    end
    $display("test carrier done");
    wr(OFS_INT_STATUS, 32'h3);
    start(32'h81);
    // Pin follows the control write two registers later
    repeat (2) @(posedge hclk);
    repeat (40) begin
      @(posedge hclk);
      chk("no carrier pin", {31'h0, pin}, 32'h1);
    end
    rd("overflow flag", OFS_INT_STATUS, 32'h1);
    wr(OFS_TMA_CONTROL, 32'h83);
    rd("env detect select", OFS_TIMER_SELECT, 32'h80);
    chk("env detect pin", {31'h0, pin}, 32'h0);
    wr(OFS_TMA_CONTROL, 32'h01);
    bus(1'b0, OFS_TMA_PRELOAD_LOW, 32'h0, r2);
    rd("stopped count", OFS_TMA_PRELOAD_LOW, r2);
    chk("stopped pin", {31'h0, pin}, 32'h0);
    start(32'h81);
    wr(OFS_TMA_CONTROL, 32'h82);
    rd("capture select", OFS_TIMER_SELECT, 32'h80);
    chk("capture pin", {31'h0, pin}, 32'h0);
    $display("test modes done");
    wr(OFS_TMA_CONTROL, 32'h0);
    wr(OFS_INT_MASK, 32'h1);
    rd("status", OFS_INT_STATUS, 32'h1);
    chk("irq on", {31'h0, irq}, 32'h1);
    wr(OFS_INT_MASK, 32'h0);
    rd("status", OFS_INT_STATUS, 32'h1);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(OFS_INT_MASK, 32'h1);
    wr(OFS_INT_STATUS, 32'h1);
    rd("status cleared", OFS_INT_STATUS, 32'h0);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    $display("test interrupt done");
    wr(OFS_INT_MASK, 32'h0);
    start(32'h8c);
    wr(OFS_TMB_PRELOAD_LOW, 32'hfd);
    wr(OFS_TMB_PRELOAD_HIGH, 32'hf);
    wr(OFS_TMB_CONTROL, 32'hb0);
    clr <= 1'b1;
    @(posedge hclk);
    clr <= 1'b0;
    wait_rise(8);
    chk("envelope gap", {31'h0, ml > 16}, 32'h1);
    rd("timer b flag", OFS_INT_STATUS, 32'h3);
    $display("test envelope done");
    // Timer B on an internal clock: envelope follows timer A run, so the carrier passes
    wr(OFS_TMB_CONTROL, 32'h90);
    wait_rise(3);
    chk("internal clock period", pd, 8);
    wr(OFS_INT_STATUS, 32'h3);
    repeat (16) @(posedge hclk);
    rd("timer b div4 flag", OFS_INT_STATUS, 32'h3);
    $display("test timer b clock done");
    end_of_test;
  end
endmodule
